// ### hw/fskcr_coeff_reg.sv
// One 16-bit read/write coefficient register.
// Assumes the write strobe is a single-cycle pulse from the bus slave.
`timescale 1ns/1ps
module fskcr_coeff_reg #(
	parameter logic [15:0] RST_VAL = 16'h0000
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic we_i,
	input wire logic [1:0] sel_i,
	input wire logic [15:0] wdata_i,
	output logic [15:0] q_o
);
	logic [15:0] q_q;
	wire logic [15:0] q_d = {sel_i[1] ? wdata_i[15:8] : q_q[15:8],
		sel_i[0] ? wdata_i[7:0] : q_q[7:0]};
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			q_q <= RST_VAL;
		else if (we_i)
			q_q <= q_d;
	end
	assign q_o = q_q;
endmodule

// ### hw/fskcr_gain_mul.sv
// Registered Q1.15 gain multiply of the tone amplitude.
// Assumes an unsigned amplitude; result saturates at all ones.
`timescale 1ns/1ps
module fskcr_gain_mul (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic load_i,
	input wire logic [15:0] amp_i,
	input wire logic [15:0] gain_i,
	output logic [15:0] amp_o
);
	logic [15:0] amp_q;
	wire logic [31:0] prod = 32'(amp_i) * 32'(gain_i);
	wire logic [16:0] scaled = prod[31:fskcr_pkg::GAIN_FRAC];
	wire logic [15:0] amp_d = scaled[16] ? 16'hffff : scaled[15:0];
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			amp_q <= fskcr_pkg::COEFF_RST;
		else if (load_i)
			amp_q <= amp_d;
	end
	assign amp_o = amp_q;
endmodule

// ### hw/fskcr_pkg.sv
// Constants for the FSK coefficient reload block: register map and fields.
// Assumes a 32-bit classic Wishbone slave, one register per aligned word.
package fskcr_pkg;
	localparam int COEFF_W = 16;
	localparam int ADDR_W = 10;
	// Register indices as printed; byte address is four times the index
	localparam logic [7:0] IDX_SPACE_AMP = 8'h45;
	localparam logic [7:0] IDX_SPACE_FREQ = 8'h46;
	localparam logic [7:0] IDX_MARK_AMP = 8'h47;
	localparam logic [7:0] IDX_MARK_FREQ = 8'h48;
	localparam logic [7:0] IDX_GAIN_S2M = 8'h49;
	localparam logic [7:0] IDX_GAIN_M2S = 8'h4a;
	localparam logic [7:0] IDX_MODE = 8'h6c;
	localparam logic [7:0] IDX_OSC_CTRL = 8'h20;
	localparam logic [7:0] IDX_TONE_AMP = 8'h50;
	localparam logic [7:0] IDX_TONE_FREQ = 8'h51;
	localparam logic [7:0] IDX_STATUS = 8'h52;
	localparam int MODE_FSK_BIT = 6;
	localparam int OSC_REL_BIT = 6;
	localparam logic [15:0] COEFF_RST = 16'h0000;
	// Gain factors are unsigned Q1.15: 16'h8000 is unity
	localparam logic [15:0] GAIN_UNITY = 16'h8000;
	localparam int GAIN_FRAC = 15;
endpackage

// ### hw/fskcr_top.sv
// Enhanced FSK coefficient reload for tone oscillator 1, with Wishbone regs.
// Assumes expiry is a one-cycle pulse and symbol is stable at that pulse.
`timescale 1ns/1ps
module fskcr_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [fskcr_pkg::ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	input wire logic timer_expire_i,
	input wire logic symbol_i,
	output logic [15:0] tone1_amp_coeff_o,
	output logic [15:0] tone1_freq_coeff_o,
	output logic tone1_load_o
);
	localparam int NREG = 6;
	logic ack_q;
	logic err_q;
	logic [31:0] rdata_q;
	logic fsk_en_q;
	logic rel_en_q;
	logic prev_sym_q;
	logic sym_valid_q;
	logic [15:0] freq_q;
	logic load_q;
	logic [15:0] regular_amp_q;
	logic [15:0] regular_freq_q;
	logic [15:0] coeff [NREG];

	wire logic req = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
	wire logic [7:0] idx = wb_adr_i[fskcr_pkg::ADDR_W-1:2];
	wire logic wr = req && wb_we_i;
	wire logic hit_sa = (idx == fskcr_pkg::IDX_SPACE_AMP);
	wire logic hit_sf = (idx == fskcr_pkg::IDX_SPACE_FREQ);
	wire logic hit_ma = (idx == fskcr_pkg::IDX_MARK_AMP);
	wire logic hit_mf = (idx == fskcr_pkg::IDX_MARK_FREQ);
	wire logic hit_g01 = (idx == fskcr_pkg::IDX_GAIN_S2M);
	wire logic hit_g10 = (idx == fskcr_pkg::IDX_GAIN_M2S);
	wire logic hit_mode = (idx == fskcr_pkg::IDX_MODE);
	wire logic hit_osc = (idx == fskcr_pkg::IDX_OSC_CTRL);
	wire logic hit_ta = (idx == fskcr_pkg::IDX_TONE_AMP);
	wire logic hit_tf = (idx == fskcr_pkg::IDX_TONE_FREQ);
	wire logic hit_st = (idx == fskcr_pkg::IDX_STATUS);
	wire logic [NREG-1:0] hit_c = {hit_g10, hit_g01, hit_mf, hit_ma,
		hit_sf, hit_sa};
	wire logic hit_any = (|hit_c) || hit_mode || hit_osc || hit_ta
		|| hit_tf || hit_st;

	// Six coefficient registers, 16 bits each in the low half-word
	genvar gi;
	generate
		for (gi = 0; gi < NREG; gi++)
		begin : g_coeff
			fskcr_coeff_reg #(
				.RST_VAL(fskcr_pkg::COEFF_RST)
			) u_reg (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.we_i(wr && hit_c[gi]),
				.sel_i(wb_sel_i[1:0]),
				.wdata_i(wb_dat_i[15:0]),
				.q_o(coeff[gi])
			);
		end
	endgenerate

	// Enable bits
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			fsk_en_q <= 1'b0;
			rel_en_q <= 1'b0;
		end
		else
		begin
			if (wr && hit_mode && wb_sel_i[0])
				fsk_en_q <= wb_dat_i[fskcr_pkg::MODE_FSK_BIT];
			if (wr && hit_osc && wb_sel_i[0])
				rel_en_q <= wb_dat_i[fskcr_pkg::OSC_REL_BIT];
		end
	end

	// Regular tone coefficients
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			regular_amp_q <= fskcr_pkg::COEFF_RST;
			regular_freq_q <= fskcr_pkg::COEFF_RST;
		end
		else
		begin
			if (wr && hit_ta)
				regular_amp_q <= wb_dat_i[15:0];
			if (wr && hit_tf)
				regular_freq_q <= wb_dat_i[15:0];
		end
	end

	// Reload selection
	wire logic fsk_active = fsk_en_q && rel_en_q;
	wire logic [15:0] space_amp = coeff[0];
	wire logic [15:0] space_freq = coeff[1];
	wire logic [15:0] mark_amp = coeff[2];
	wire logic [15:0] mark_freq = coeff[3];
	wire logic [15:0] gain_s2m = coeff[4];
	wire logic [15:0] gain_m2s = coeff[5];
	wire logic [15:0] fsk_amp = symbol_i ? mark_amp : space_amp;
	wire logic [15:0] fsk_freq = symbol_i ? mark_freq : space_freq;
	wire logic changed = sym_valid_q && (symbol_i != prev_sym_q);
	wire logic s2m = changed && symbol_i;
	wire logic m2s = changed && !symbol_i;
	wire logic [15:0] gain_sel = !fsk_active ? fskcr_pkg::GAIN_UNITY :
		s2m ? gain_s2m :
		m2s ? gain_m2s :
		fskcr_pkg::GAIN_UNITY;
	wire logic [15:0] amp_src = fsk_active ? fsk_amp : regular_amp_q;
	wire logic [15:0] freq_src = fsk_active ? fsk_freq : regular_freq_q;

	fskcr_gain_mul u_mul (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.load_i(timer_expire_i),
		.amp_i(amp_src),
		.gain_i(gain_sel),
		.amp_o(tone1_amp_coeff_o)
	);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			freq_q <= fskcr_pkg::COEFF_RST;
			load_q <= 1'b0;
			prev_sym_q <= 1'b0;
			sym_valid_q <= 1'b0;
		end
		else
		begin
			load_q <= timer_expire_i;
			if (timer_expire_i)
			begin
				freq_q <= freq_src;
				prev_sym_q <= symbol_i;
				sym_valid_q <= fsk_active;
			end
			else if (!fsk_active)
				sym_valid_q <= 1'b0;
		end
	end

	assign tone1_freq_coeff_o = freq_q;
	assign tone1_load_o = load_q;

	// Read mux
	wire logic [15:0] coeff_rd = hit_sa ? coeff[0] :
		hit_sf ? coeff[1] :
		hit_ma ? coeff[2] :
		hit_mf ? coeff[3] :
		hit_g01 ? coeff[4] :
		hit_g10 ? coeff[5] : 16'h0000;
	logic [31:0] rd_d;
	always_comb
	begin
		rd_d = 32'h0000_0000;
		if (|hit_c)
			rd_d = {16'h0000, coeff_rd};
		else if (hit_mode)
			rd_d[fskcr_pkg::MODE_FSK_BIT] = fsk_en_q;
		else if (hit_osc)
			rd_d[fskcr_pkg::OSC_REL_BIT] = rel_en_q;
		else if (hit_ta)
			rd_d = {16'h0000, regular_amp_q};
		else if (hit_tf)
			rd_d = {16'h0000, regular_freq_q};
		else if (hit_st)
			rd_d = {14'h0000, fsk_active, prev_sym_q, tone1_amp_coeff_o};
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_q <= 1'b0;
			err_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end
		else
		begin
			ack_q <= req && hit_any;
			err_q <= req && !hit_any;
			if (req && !wb_we_i)
				rdata_q <= rd_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_err_o = err_q;
	assign wb_dat_o = rdata_q;
endmodule

// ### verif/fskcr_top_props.sv
// Checker of the reload block's bus and oscillator ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module fskcr_top_props (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [fskcr_pkg::ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic wb_err_o,
	input wire logic timer_expire_i,
	input wire logic symbol_i,
	input wire logic [15:0] tone1_amp_coeff_o,
	input wire logic [15:0] tone1_freq_coeff_o,
	input wire logic tone1_load_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_load_after_expiry: assert property (timer_expire_i |=> tone1_load_o)
		else $error("no load after expiry");
	a_load_only_expiry: assert property (!timer_expire_i |=> !tone1_load_o)
		else $error("load without expiry");
	a_amp_hold: assert property (!timer_expire_i |=> $stable(tone1_amp_coeff_o))
		else $error("amplitude moved without expiry");
	a_freq_hold: assert property (!timer_expire_i |=> $stable(tone1_freq_coeff_o))
		else $error("frequency moved without expiry");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_bus_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
		|=> wb_ack_o || wb_err_o)
		else $error("request not answered");
	a_no_stray_ack: assert property (!(wb_cyc_i && wb_stb_i)
		|=> !wb_ack_o && !wb_err_o)
		else $error("answer without request");
	a_coeff_upper_zero: assert property (wb_ack_o && !$past(wb_we_i)
		&& $past(wb_adr_i[9:2]) inside {[8'h45:8'h4a]} |-> wb_dat_o[31:16] == 16'h0)
		else $error("coefficient upper bits not zero");
endmodule
bind fskcr_top fskcr_top_props props_i (.*);

// ### verif/fskcr_top_test.sv
// Self-checking bench of the reload block, registers set over Wishbone.
// Assumes a registered ack or err one cycle after the request is taken.
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
$display("wrong value at %0t: %h %h", $time, g, e); end end
module fskcr_top_test;
	logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, exp_i = 0, sym = 0, err, prev;
	logic first, wb_ack_o, wb_err_o, tone1_load_o;
	logic [9:0] adr = 0;
	logic [31:0] dat = 0, rd, wb_dat_o;
	logic [15:0] tone1_amp_coeff_o, tone1_freq_coeff_o;
	logic [15:0] c [8];
	int n_mismatch = 0, comparisons = 0, cycles = 0;
	fskcr_top uut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
		.wb_dat_o, .wb_ack_o, .wb_err_o, .timer_expire_i(exp_i),
		.symbol_i(sym), .tone1_amp_coeff_o, .tone1_freq_coeff_o,
		.tone1_load_o);
	initial
		forever #12.5 clk_i = ~clk_i;
	function automatic logic [15:0] gmul(input logic [15:0] a, g);
		logic [31:0] p;
		p = ({16'h0, a} * {16'h0, g}) >> fskcr_pkg::GAIN_FRAC;
		return (p > 32'hffff) ? 16'hffff : p[15:0];
	endfunction
	task automatic summarize();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] idx,
		input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1;
		we <= w;
		adr <= {idx, 2'b00};
		dat <= d;
		do
			@(posedge clk_i);
		while (!(wb_ack_o | wb_err_o));
		rd = wb_dat_o;
		err = wb_err_o;
		cyc <= 0;
	endtask
	// One expiry; on selects the FSK expectation
	task automatic fire(input logic on, input logic s);
		logic [15:0] a;
		a = on ? (s ? c[2] : c[0]) : c[6];
		if (on && !first && s != prev)
			a = gmul(a, s ? c[4] : c[5]);
		@(posedge clk_i);
		exp_i <= 1;
		sym <= s;
		@(posedge clk_i);
		exp_i <= 0;
		@(posedge clk_i);
		`CHK(tone1_load_o, 1'b1)
		`CHK(tone1_amp_coeff_o, a)
		`CHK(tone1_freq_coeff_o, on ? (s ? c[3] : c[1]) : c[7])
		prev = s;
		first = !on;
	endtask
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_mismatch++;
			summarize();
		end
	end
	initial
	begin
		void'($urandom(80598));
		repeat (5) @(posedge clk_i);
		rst_i <= 0;
		foreach (c[i])
		begin
			c[i] = (i == 4) ? 16'hffff : 16'($urandom);
			bus(1, i < 6 ? 8'(fskcr_pkg::IDX_SPACE_AMP + i)
				: 8'(fskcr_pkg::IDX_TONE_AMP + i - 6), {16'($urandom), c[i]});
		end
		for (int i = 0; i < 6; i++)
		begin
			bus(0, 8'(fskcr_pkg::IDX_SPACE_AMP + i), 32'h0);
			`CHK(rd, {16'h0, c[i]})
		end
		bus(0, 8'h10, 32'h0);
		`CHK(err, 1'b1)
		first = 1;
		fire(0, 1);
		bus(1, fskcr_pkg::IDX_MODE, 32'h40);
		bus(0, fskcr_pkg::IDX_MODE, 32'h0);
		`CHK(rd, 32'h0000_0040)
		fire(0, 0);
		bus(1, fskcr_pkg::IDX_OSC_CTRL, 32'h40);
		fire(1, 1);
		fire(1, 1);
		fire(1, 0);
		fire(1, 1);
		repeat (16) fire(1, 1'($urandom));
		bus(1, fskcr_pkg::IDX_MODE, 32'h0);
		fire(0, 0);
		fire(0, 1);
		summarize();
	end
endmodule
